/* common/dfm_regs.vh */
`ifndef DFM_REGS_VH
`define DFM_REGS_VH
// parameter value ranges
`define DFM_ACT_FAULT_MAX 2'h2
`define DFM_CTRL_OLV 2'h2
`define DFM_CTRL_CLV_A 2'h1
`define DFM_CTRL_CLV_B 2'h3
`define DFM_PID_ACT_FAULT 2'h2
`define DFM_RUN_SRC_KEYPAD 2'h0
// timing
`define DFM_CLK_HZ 25000000
`define DFM_TIME_UNIT_HZ 1000
`define DFM_DECEL_TL_MS 3000
`define DFM_DECEL_TL_CYC (`DFM_DECEL_TL_MS * (`DFM_CLK_HZ / `DFM_TIME_UNIT_HZ))
`define DFM_MS_CYC (`DFM_CLK_HZ / `DFM_TIME_UNIT_HZ)
// fault code bit positions
`define DFM_F_ENC 0
`define DFM_F_SPD 1
`define DFM_F_HOLD 2
`define DFM_F_DECEL 3
`define DFM_F_PID 4
`define DFM_F_OPT 5
`define DFM_F_TERM3 6
`define DFM_F_KEYPAD 11
`define DFM_NFAULT 12
`define DFM_FAULT_RST 12'h000
`endif

/* hw/dfm_monitor.v */
`timescale 1ns/1ps
`include "dfm_regs.vh"
module dfm_monitor #(
  parameter SPD_W = 16,
  parameter POS_W = 24,
  parameter FB_W = 12,
  parameter TIME_W = 16,
  parameter MS_CYC = `DFM_MS_CYC,
  parameter DECEL_TL_CYC = `DFM_DECEL_TL_CYC
) (
  input wire i_mclk,
  input wire i_srst,
  input wire i_fault_reset,
  input wire [1:0] i_control_method_select,
  input wire [1:0] i_encoder_loss_action,
  input wire [TIME_W-1:0] i_encoder_loss_time,
  input wire i_pulse_encoder,
  input wire [1:0] i_speed_error_action,
  input wire [SPD_W-1:0] i_speed_error_level,
  input wire [TIME_W-1:0] i_speed_error_time,
  input wire signed [SPD_W-1:0] i_speed_error,
  input wire i_hold_active,
  input wire [POS_W-1:0] i_hold_position,
  input wire [POS_W-1:0] i_motor_position,
  input wire i_decel_stop,
  input wire i_torque_limit_reached,
  input wire [1:0] i_pid_loss_action,
  input wire [FB_W-1:0] i_pid_loss_level,
  input wire [TIME_W-1:0] i_pid_loss_time,
  input wire [FB_W-1:0] i_pid_feedback,
  input wire i_option_card_fault,
  input wire [4:0] i_multi_function_inputs,
  input wire [4:0] i_ext_fault_select,
  input wire [1:0] i_run_command_source,
  input wire i_keypad_present,
  output wire o_encoder_loss_fault,
  output wire o_speed_error_fault,
  output wire o_hold_position_fault,
  output wire o_decel_torque_limit_fault,
  output wire o_pid_feedback_loss_fault,
  output wire o_option_card_ext_fault,
  output wire o_terminal3_ext_fault,
  output wire o_terminal4_ext_fault,
  output wire o_terminal5_ext_fault,
  output wire o_terminal6_ext_fault,
  output wire o_terminal7_ext_fault,
  output wire o_keypad_detach_fault,
  output wire o_any_fault
);
  localparam MSW = 32;

  function closed_loop;
    input [1:0] method;
    begin
      closed_loop = (method == `DFM_CTRL_CLV_A) || (method == `DFM_CTRL_CLV_B);
    end
  endfunction

  function action_enabled;
    input [1:0] act;
    begin
      action_enabled = (act <= `DFM_ACT_FAULT_MAX);
    end
  endfunction

  // millisecond tick shared by the configurable timers
  reg [MSW-1:0] ms_cnt_q;
  reg ms_tick_q;
  always @(posedge i_mclk) begin
    if (i_srst) begin
      ms_cnt_q <= {MSW{1'b0}};
      ms_tick_q <= 1'b0;
    end else if (ms_cnt_q >= MS_CYC - 1) begin
      ms_cnt_q <= {MSW{1'b0}};
      ms_tick_q <= 1'b1;
    end else begin
      ms_cnt_q <= ms_cnt_q + {{(MSW-1){1'b0}}, 1'b1};
      ms_tick_q <= 1'b0;
    end
  end

  // encoder loss: pulse edge restarts silence timer
  reg enc_pulse_q;
  always @(posedge i_mclk) begin
    if (i_srst) begin
      enc_pulse_q <= 1'b0;
    end else begin
      enc_pulse_q <= i_pulse_encoder;
    end
  end
  wire enc_edge = i_pulse_encoder & ~enc_pulse_q;
  wire enc_en = action_enabled(i_encoder_loss_action) && closed_loop(i_control_method_select);
  wire enc_cond = enc_en && !enc_edge;
  wire enc_trip;
  dfm_timer #(.W(TIME_W)) u_enc_tmr (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_cond(enc_cond),
    .i_tick(ms_tick_q),
    .i_limit(i_encoder_loss_time),
    .i_strict(1'b1),
    .o_expired(enc_trip)
  );

  // speed error magnitude
  wire [SPD_W-1:0] spd_mag = i_speed_error[SPD_W-1] ? (~i_speed_error + {{(SPD_W-1){1'b0}}, 1'b1})
                                                     : i_speed_error;
  wire spd_en = action_enabled(i_speed_error_action) && closed_loop(i_control_method_select);
  wire spd_cond = spd_en && (spd_mag > i_speed_error_level);
  wire spd_trip;
  dfm_timer #(.W(TIME_W)) u_spd_tmr (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_cond(spd_cond),
    .i_tick(ms_tick_q),
    .i_limit(i_speed_error_time),
    .i_strict(1'b1),
    .o_expired(spd_trip)
  );

  wire hold_trip = i_hold_active && (i_motor_position != i_hold_position);

  // decel stop torque limit, counted in clocks
  reg [MSW-1:0] decel_cnt_q;
  wire decel_cond = (i_control_method_select == `DFM_CTRL_OLV) && i_decel_stop && i_torque_limit_reached;
  always @(posedge i_mclk) begin
    if (i_srst || !decel_cond) begin
      decel_cnt_q <= {MSW{1'b0}};
    end else if (decel_cnt_q < DECEL_TL_CYC) begin
      decel_cnt_q <= decel_cnt_q + {{(MSW-1){1'b0}}, 1'b1};
    end
  end
  wire decel_trip = decel_cond && (decel_cnt_q >= DECEL_TL_CYC - 1);

  wire pid_en = (i_pid_loss_action == `DFM_PID_ACT_FAULT);
  wire pid_cond = pid_en && (i_pid_feedback < i_pid_loss_level);
  wire pid_trip;
  dfm_timer #(.W(TIME_W)) u_pid_tmr (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_cond(pid_cond),
    .i_tick(ms_tick_q),
    .i_limit(i_pid_loss_time),
    .i_strict(1'b0),
    .o_expired(pid_trip)
  );

  wire opt_trip = i_option_card_fault;
  wire [4:0] term_trip = i_multi_function_inputs & i_ext_fault_select;
  wire key_trip = (i_run_command_source == `DFM_RUN_SRC_KEYPAD) && !i_keypad_present;

  wire [`DFM_NFAULT-1:0] trip = {key_trip, term_trip, opt_trip, pid_trip, decel_trip,
                                 hold_trip, spd_trip, enc_trip};

  // latched fault codes; a new trip wins over reset
  reg [`DFM_NFAULT-1:0] fault_q;
  reg [`DFM_NFAULT-1:0] fault_d;
  always @* begin
    fault_d = fault_q;
    if (i_fault_reset) begin
      fault_d = `DFM_FAULT_RST;
    end
    fault_d = fault_d | trip;
  end
  // summary flag registered alongside the latch
  reg any_fault_q;
  always @(posedge i_mclk) begin
    if (i_srst) begin
      fault_q <= `DFM_FAULT_RST;
      any_fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
      any_fault_q <= |fault_d;
    end
  end

  assign o_encoder_loss_fault = fault_q[`DFM_F_ENC];
  assign o_speed_error_fault = fault_q[`DFM_F_SPD];
  assign o_hold_position_fault = fault_q[`DFM_F_HOLD];
  assign o_decel_torque_limit_fault = fault_q[`DFM_F_DECEL];
  assign o_pid_feedback_loss_fault = fault_q[`DFM_F_PID];
  assign o_option_card_ext_fault = fault_q[`DFM_F_OPT];
  assign o_terminal3_ext_fault = fault_q[`DFM_F_TERM3];
  assign o_terminal4_ext_fault = fault_q[`DFM_F_TERM3 + 1];
  assign o_terminal5_ext_fault = fault_q[`DFM_F_TERM3 + 2];
  assign o_terminal6_ext_fault = fault_q[`DFM_F_TERM3 + 3];
  assign o_terminal7_ext_fault = fault_q[`DFM_F_TERM3 + 4];
  assign o_keypad_detach_fault = fault_q[`DFM_F_KEYPAD];
  assign o_any_fault = any_fault_q;
endmodule

/* hw/dfm_timer.v */
`timescale 1ns/1ps
// counts condition time in units of tick; restarts when condition drops
module dfm_timer #(
  parameter W = 16
) (
  input wire i_mclk,
  input wire i_srst,
  input wire i_cond,
  input wire i_tick,
  input wire [W-1:0] i_limit,
  input wire i_strict,
  output wire o_expired
);
  reg [W-1:0] cnt_q;
  reg [W-1:0] cnt_d;
  always @* begin
    cnt_d = cnt_q;
    if (!i_cond) begin
      cnt_d = {W{1'b0}};
    end else if (i_tick && cnt_q != {W{1'b1}}) begin
      cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge i_mclk) begin
    if (i_srst) begin
      cnt_q <= {W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign o_expired = i_cond && (i_strict ? (cnt_q > i_limit) : (cnt_q >= i_limit));
endmodule

/* tb/dfm_monitor_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t mismatch", $time); end end
module dfm_monitor_tb_top;
  localparam M = 4;
  localparam D = 6;
  int n_mismatch = 0, cmp_count = 0, seed = 69;
  logic [31:0] r;
  logic i_mclk = 0, i_srst = 1, i_fault_reset = 0, i_hold_active = 0, i_decel_stop = 0, i_torque_limit_reached = 0;
  logic run = 0, i_option_card_fault = 0, i_keypad_present = 1;
  logic [1:0] i_control_method_select = 2'h1, i_encoder_loss_action = 2'h3, i_speed_error_action = 2'h3;
  logic [1:0] i_pid_loss_action = 2'h0, i_run_command_source = 2'h1;
  logic [15:0] i_encoder_loss_time = 16'h2, i_speed_error_time = 16'h2, i_pid_loss_time = 16'h2;
  logic [15:0] i_speed_error_level = 16'hA, i_speed_error = 16'h0;
  logic [23:0] i_hold_position = 24'h0, i_motor_position = 24'h0;
  logic [11:0] i_pid_loss_level = 12'h64, i_pid_feedback = 12'hC8;
  logic [4:0] i_multi_function_inputs = 5'h0, i_ext_fault_select = 5'h0;
  logic [7:0] m = 8'h0;
  wire i_pulse_encoder, o_any_fault, o_encoder_loss_fault, o_speed_error_fault, o_hold_position_fault;
  wire o_decel_torque_limit_fault, o_pid_feedback_loss_fault, o_option_card_ext_fault, o_keypad_detach_fault;
  wire o_terminal3_ext_fault, o_terminal4_ext_fault, o_terminal5_ext_fault, o_terminal6_ext_fault, o_terminal7_ext_fault;
  wire [3:0] tf = {o_decel_torque_limit_fault, o_pid_feedback_loss_fault, o_speed_error_fault, o_encoder_loss_fault};
  wire [7:0] got = {o_hold_position_fault, o_keypad_detach_fault, o_terminal7_ext_fault, o_terminal6_ext_fault,
    o_terminal5_ext_fault, o_terminal4_ext_fault, o_terminal3_ext_fault, o_option_card_ext_fault};
  wire [7:0] trp = {i_hold_active && i_hold_position != i_motor_position, i_run_command_source == 2'h0 &&
    !i_keypad_present, i_multi_function_inputs & i_ext_fault_select, i_option_card_fault};
  dfm_monitor #(.MS_CYC(M), .DECEL_TL_CYC(D)) DUT (.*);
  dfm_partner u_enc (.i_mclk, .i_run(run), .o_pulse(i_pulse_encoder));
  always #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) m <= i_srst ? 8'h0 : trp | (m & {8{!i_fault_reset}});
  always @(negedge i_mclk) if (!i_srst) `CHK(got, m)
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task done;
    $display("test done at %0t", $time);
    i_srst = 1;
    cyc(5);
    i_srst = 0;
  endtask
  // cycles until a timed fault shows, within bounds
  task tw(input int i, lo, hi);
    int n;
    n = 0;
    while (tf[i] !== 1'b1 && n < 99) begin
      cyc(1);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
    `CHK(o_any_fault, 1'b1)
    if (n == 99) wrap_up;
  endtask
  initial begin
    cyc(5);
    i_srst = 0;
    repeat (60) begin
      cyc(1);
      r = $random(seed);
      i_multi_function_inputs = r[4:0];
      i_ext_fault_select = r[9:5];
      i_option_card_fault = &r[11:10];
      i_hold_active = r[12];
      i_motor_position = {23'h0, r[13]};
      i_keypad_present = |r[15:14];
      i_run_command_source = r[17:16];
      i_fault_reset = &r[19:18];
    end
    cyc(1);
    i_multi_function_inputs = 5'h0;
    i_option_card_fault = 0;
    i_hold_active = 0;
    i_keypad_present = 1;
    i_fault_reset = 0;
    i_control_method_select = 2'h2;
    i_encoder_loss_action = 2'h0;
    i_speed_error_action = 2'h0;
    i_speed_error = 16'h14;
    i_pid_loss_action = 2'h1;
    i_pid_feedback = 12'h32;
    cyc(5 * M);
    `CHK(tf, 4'h0)
    done;
    i_control_method_select = 2'h1;
    i_encoder_loss_action = 2'h3;
    cyc(3 * M);
    i_speed_error = 16'h0;
    cyc(2);
    i_speed_error = 16'hFFEC;
    tw(1, 2 * M, 3 * M + 3);
    `CHK(tf[0], 1'b0)
    done;
    i_speed_error_action = 2'h3;
    i_encoder_loss_action = 2'h2;
    i_control_method_select = 2'h3;
    run = 1;
    cyc(5 * M);
    `CHK(tf, 4'h0)
    run = 0;
    tw(0, M, 3 * M + 3);
    done;
    i_encoder_loss_action = 2'h3;
    i_pid_loss_action = 2'h2;
    tw(2, M, 2 * M + 3);
    done;
    i_pid_loss_action = 2'h0;
    i_control_method_select = 2'h2;
    i_decel_stop = 1;
    i_torque_limit_reached = 1;
    cyc(D - 2);
    i_torque_limit_reached = 0;
    cyc(1);
    i_torque_limit_reached = 1;
    tw(3, D - 1, D + 2);
    i_decel_stop = 0;
    i_fault_reset = 1;
    cyc(1);
    i_fault_reset = 0;
    cyc(2);
    `CHK(tf, 4'h0)
    `CHK(o_any_fault, 1'b0)
    done;
    wrap_up;
  end
endmodule

/* tb/dfm_partner.sv */
`timescale 1ns/1ps
module dfm_partner (
  input wire i_mclk,
  input wire i_run,
  output wire o_pulse
);
  logic [1:0] ph_q = 2'h0;
  // one pulse per 4 clocks, shaft still when stopped
  always @(posedge i_mclk) if (i_run) ph_q <= ph_q + 2'h1;
  assign o_pulse = ph_q[1];
endmodule

/* tb/dfm_properties.sv */
`timescale 1ns/1ps
module dfm_properties #(
  parameter DECEL_TL_CYC = 20,
  parameter POS_W = 24
) (
  input wire i_mclk, i_srst, i_fault_reset, i_decel_stop, i_torque_limit_reached, i_option_card_fault,
  input wire i_keypad_present, i_hold_active,
  input wire [POS_W-1:0] i_hold_position, i_motor_position,
  input wire [1:0] i_control_method_select, i_speed_error_action, i_pid_loss_action, i_run_command_source,
  input wire [4:0] i_multi_function_inputs, i_ext_fault_select,
  input wire o_speed_error_fault, o_decel_torque_limit_fault, o_pid_feedback_loss_fault, o_hold_position_fault,
  input wire o_option_card_ext_fault, o_terminal3_ext_fault, o_keypad_detach_fault, o_any_fault
);
  int tl_q = 0;
  wire tl_c = i_decel_stop && i_torque_limit_reached && i_control_method_select == 2'h2;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // run length of torque limit in a decel stop
  always @(posedge i_mclk) tl_q <= (i_srst || !tl_c) ? 0 : tl_q + 1;
  property p_opt; i_option_card_fault |=> o_option_card_ext_fault; endproperty
  a_opt: assert property (p_opt) else $error("option fault missed");
  property p_t3; i_multi_function_inputs[0] && i_ext_fault_select[0] |=> o_terminal3_ext_fault; endproperty
  a_t3: assert property (p_t3) else $error("terminal fault missed");
  property p_kpd; i_run_command_source == 2'h0 && !i_keypad_present |=> o_keypad_detach_fault; endproperty
  a_kpd: assert property (p_kpd) else $error("keypad fault missed");
  property p_latch; o_any_fault && !i_fault_reset |=> o_any_fault; endproperty
  a_latch: assert property (p_latch) else $error("fault dropped");
  property p_pid; $rose(o_pid_feedback_loss_fault) |-> $past(i_pid_loss_action) == 2'h2; endproperty
  a_pid: assert property (p_pid) else $error("pid fault while off");
  property p_spd; $rose(o_speed_error_fault) |-> $past(i_speed_error_action) <= 2'h2; endproperty
  a_spd: assert property (p_spd) else $error("speed fault while off");
  property p_hold; i_hold_active && i_hold_position != i_motor_position |=> o_hold_position_fault; endproperty
  a_hold: assert property (p_hold) else $error("hold fault missed");
  // condition sampled for the full count at this edge
  sequence s_tl_full; tl_c && tl_q >= DECEL_TL_CYC - 1; endsequence
  property p_dcl; s_tl_full |=> o_decel_torque_limit_fault; endproperty
  a_dcl: assert property (p_dcl) else $error("decel fault late");
  property p_dcl_e; $rose(o_decel_torque_limit_fault) |-> $past(tl_q) >= DECEL_TL_CYC - 1; endproperty
  a_dcl_e: assert property (p_dcl_e) else $error("decel fault early");
endmodule
bind dfm_monitor dfm_properties #(.DECEL_TL_CYC(DECEL_TL_CYC), .POS_W(POS_W)) u_props (.*);
